// ---- core/bcr_bcd_field.sv ----
module bcr_bcd_field (
  input wire logic [7:0] val, // present bcd value
  input wire logic [7:0] lo, // value after wrap
  input wire logic [7:0] hi, // last value before wrap
  input wire logic cin, // carry into this field
  output logic [7:0] nxt, // next value
  output logic cout // carry out of this field
);
  wire at_hi = (val == hi);
  wire units_nine = (val[3:0] == 4'h9);
  wire [7:0] inc_val = units_nine ? {val[7:4] + 4'h1, 4'h0} : {val[7:4], val[3:0] + 4'h1};
  assign cout = cin && at_hi;
  assign nxt = !cin ? val : (at_hi ? lo : inc_val);
endmodule : bcr_bcd_field

// ---- core/bcr_clock_core.sv ----
// Function
// - read-halt bit set stops copying counters into the clock registers
// - while halted, registers keep the time present when the halt came
// - halting the copy never stops or disturbs the running counters
// - all clock registers update together; a halt lets a running copy finish
// - copying resumes within a second after the read-halt bit clears
// - load bit set also halts copying so the host can write new time
// - load bit falling moves all time registers into the counters
// - year is BCD 00-99, month BCD 01-12 with upper bits zero
// - date is BCD 01-31 with two-bit tens, upper bits zero
// - weekday 01-07 plus frequency-test bit; hours BCD 00-23
// - minutes and seconds BCD 00-59; seconds carries the stop bit
// - stop bit set halts the oscillator; it resets to one
// - oscillator runs again within a second after stop clears
// - 32768 Hz source, calibration acts at the divide-by-256 stage
// - control low five bits are trim magnitude, bit five its sign
// - 64-minute cycle; one second per minute shortened 128 or lengthened 256
// - magnitude N trims only the first 2N minutes of the cycle
// - test bit set and running: seconds bit zero toggles at 512 Hz
// - stop and test bits take effect without the load bit
// - 11 address lines; read when chip select and output enable low and write strobe high
// - write spans the overlap of chip select and write strobe low
module bcr_clock_core #(
  parameter int unsigned OSC_HZ = bcr_pkg::OSC_HZ
) (
  input wire logic CLOCK, // 10 MHz system clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic OSC_IN, // 32768 Hz oscillator pin
  input wire logic [bcr_pkg::ADDR_W-1:0] ADDR, // byte address
  input wire logic E_N, // chip select, active low
  input wire logic W_N, // write strobe, active low
  input wire logic G_N, // output enable, active low
  input wire logic [7:0] DQ_IN, // data pins as read in
  output logic [7:0] DQ_OUT, // data pins as driven
  output logic DQ_OE // high while data pins are driven
);
  import bcr_pkg::*;

  localparam int unsigned SW = ADDR_W + 12;

  // the decode takes the register block as the top eight bytes of the map
  if (NBANK != 8 || NFIELD != NBANK - 1 || ADDR_W < 4) begin : g_bad_map
    $error("register map does not fit the address decode");
  end

  function automatic logic [3:0] map_addr(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a[ADDR_W-1:3] == OFF_CTRL[ADDR_W-1:3]);
    map_addr = {hit, a[2:0] - OFF_CTRL[2:0]};
  endfunction : map_addr

  // pin synchroniser
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  wire [SW-1:0] pins = {OSC_IN, E_N, W_N, G_N, ADDR, DQ_IN};
  // strobes reset to their idle high level so release shows no false write end
  localparam logic [SW-1:0] PINS_IDLE = {1'b0, 3'b111, {(ADDR_W + 8){1'b0}}};

  wire osc_s = s2_q[SW-1];
  wire e_n_s = s2_q[SW-2];
  wire w_n_s = s2_q[SW-3];
  wire g_n_s = s2_q[SW-4];
  wire [ADDR_W-1:0] addr_s = s2_q[ADDR_W+7:8];
  wire [7:0] din_s = s2_q[7:0];

  // oscillator edge
  logic osc_prev_q;
  logic osc_tick_q;

  // bus capture
  logic wr_prev_q;
  logic [ADDR_W-1:0] wa_q;
  logic [7:0] wd_q;
  logic [7:0] dq_out_q;
  logic dq_oe_q;

  // register bank and counters
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [6:0][7:0] bank_q;
  logic [6:0][7:0] bank_d;
  logic [6:0][7:0] cnt_q;
  logic [6:0][7:0] cnt_d;

  // carry chain
  logic [6:0][7:0] nxt;
  logic [6:0][7:0] hi_w;
  logic [6:0] cin;
  logic [6:0] cout;

  bcr_div_if dif ();

  bcr_divider #(
    .OSC_HZ(OSC_HZ)
  ) u_div (
    .clk(CLOCK),
    .rst_n(RST_N),
    .dif(dif)
  );

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      s1_q <= PINS_IDLE;
      s2_q <= PINS_IDLE;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  // stop bit gates the oscillator
  wire run = !bank_q[SEC_F][STOP_BIT];
  wire osc_rise = osc_s && !osc_prev_q;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      osc_prev_q <= 1'b0;
      osc_tick_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_s;
      osc_tick_q <= osc_rise && run;
    end
  end

  assign dif.osc_tick = osc_tick_q;
  assign dif.cal_mag = ctl_q[CAL_W-1:0];
  assign dif.cal_pos = ctl_q[CTL_SIGN_BIT];
  assign dif.min_tick = cout[SEC_F];

  // write commits when the select/strobe overlap ends
  wire wr_act = !e_n_s && !w_n_s;
  wire rd_act = !e_n_s && w_n_s && !g_n_s;
  wire commit = wr_prev_q && !wr_act;
  wire [3:0] wmap = map_addr(wa_q);
  wire whit = commit && wmap[3];
  wire [2:0] widx = wmap[2:0];
  wire wr_ctl = whit && (widx == 3'h0);

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      wr_prev_q <= 1'b0;
      wa_q <= '0;
      wd_q <= 8'h00;
    end else begin
      wr_prev_q <= wr_act;
      wa_q <= wr_act ? addr_s : wa_q;
      wd_q <= wr_act ? din_s : wd_q;
    end
  end

  // control register
  wire halt = ctl_q[CTL_RD_BIT] || ctl_q[CTL_WR_BIT];
  wire load = wr_ctl && ctl_q[CTL_WR_BIT] && !wd_q[CTL_WR_BIT];

  assign ctl_d = wr_ctl ? wd_q : ctl_q;

  // clock register bank
  always_comb begin
    logic [7:0] copy;
    logic [7:0] keep;
    copy = 8'h00;
    keep = 8'h00;
    for (int i = 0; i < NFIELD; i++) begin
      keep = KEEP_MASK[i];
      // one-cycle copy of every field at once
      copy = halt ? bank_q[i] : ((bank_q[i] & keep) | cnt_q[i]);
      bank_d[i] = copy;
      if (whit && (widx == 3'(i + 1))) begin
        if (halt) begin
          bank_d[i] = wd_q;
        end else begin
          bank_d[i] = (copy & ~keep) | (wd_q & keep);
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctl_q <= CTL_RESET;
      bank_q <= BANK_RESET;
    end else begin
      ctl_q <= ctl_d;
      bank_q <= bank_d;
    end
  end

  // timekeeping counters
  assign cin[0] = dif.sec_tick;
  assign cin[1] = cout[0];
  assign cin[2] = cout[1];
  assign cin[3] = cout[HOUR_F];
  assign cin[4] = cout[HOUR_F];
  assign cin[5] = cout[MDAY_F];
  assign cin[6] = cout[MONTH_F];

  wire [7:0] dim_w = days_in_month(cnt_q[MONTH_F], cnt_q[YEAR_F]);

  for (genvar f = 0; f < NFIELD; f++) begin : g_fld
    assign hi_w[f] = (f == MDAY_F) ? dim_w : FIELD_HI[f];
    bcr_bcd_field u_fld (
      .val(cnt_q[f]),
      .lo(FIELD_LO[f]),
      .hi(hi_w[f]),
      .cin(cin[f]),
      .nxt(nxt[f]),
      .cout(cout[f])
    );
    // loading masks reserved bits so they load as zero in the counters
    assign cnt_d[f] = load ? (bank_q[f] & FIELD_MASK[f]) : nxt[f];
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      cnt_q <= CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // read path, follows the address live during a long read
  wire [3:0] rmap = map_addr(addr_s);
  wire [2:0] ridx = rmap[2:0];
  wire ftest = bank_q[WDAY_F][FTEST_BIT] && run;
  wire [7:0] sec_rd = ftest ? {bank_q[SEC_F][7:1], dif.test_wave} : bank_q[SEC_F];
  logic [NBANK-1:0][7:0] rd_cand;
  assign rd_cand[0] = ctl_q;
  assign rd_cand[1] = sec_rd;
  for (genvar r = 2; r < NBANK; r++) begin : g_rd
    assign rd_cand[r] = bank_q[r - 1];
  end
  wire [7:0] bank_rd = rd_cand[ridx];
  wire [7:0] rd_val = rmap[3] ? bank_rd : 8'h00;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      dq_out_q <= 8'h00;
      dq_oe_q <= 1'b0;
    end else begin
      dq_out_q <= rd_val;
      dq_oe_q <= rd_act;
    end
  end

  assign DQ_OUT = dq_out_q;
  assign DQ_OE = dq_oe_q;
endmodule : bcr_clock_core

// ---- core/bcr_div_if.sv ----
interface bcr_div_if;
  logic osc_tick;
  logic [4:0] cal_mag;
  logic cal_pos;
  logic min_tick;
  logic sec_tick;
  logic test_wave;
  modport core (output osc_tick, output cal_mag, output cal_pos, output min_tick,
                input sec_tick, input test_wave);
  modport div (input osc_tick, input cal_mag, input cal_pos, input min_tick,
               output sec_tick, output test_wave);
endinterface : bcr_div_if

// ---- core/bcr_divider.sv ----
module bcr_divider #(
  parameter int unsigned OSC_HZ = bcr_pkg::OSC_HZ
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  bcr_div_if.div dif // ticks to and from the core
);
  import bcr_pkg::*;
  localparam int unsigned CW = $clog2(OSC_HZ + CAL_LONG + 1);
  localparam int unsigned TW = $clog2(OSC_HZ / (2 * TEST_HZ));
  if (OSC_HZ <= CAL_SHORT || OSC_HZ < 2 * TEST_HZ) begin : g_bad_osc
    $error("oscillator rate too low for calibration or test output");
  end
  logic [CW-1:0] cnt_q;
  logic [5:0] cyc_q;
  logic first_q;
  logic sec_q;
  logic [TW:0] tw_q;
  wire cal_now = first_q && (cyc_q < {dif.cal_mag, 1'b0});
  wire [CW-1:0] len_plus = CW'(OSC_HZ + CAL_LONG);
  wire [CW-1:0] len_minus = CW'(OSC_HZ - CAL_SHORT);
  wire [CW-1:0] len = cal_now ? (dif.cal_pos ? len_minus : len_plus) : CW'(OSC_HZ);
  // a trim that shortens the second after the count passed its end still wraps on the next oscillator tick
  wire wrap = dif.osc_tick && (cnt_q >= len - CW'(1));
  assign dif.sec_tick = sec_q;
  assign dif.test_wave = tw_q[TW];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      cyc_q <= '0;
      first_q <= 1'b0;
      sec_q <= 1'b0;
      tw_q <= '0;
    end else begin
      cnt_q <= wrap ? '0 : (dif.osc_tick ? cnt_q + CW'(1) : cnt_q);
      sec_q <= wrap;
      // cycle of 64 minutes wraps on its own width
      cyc_q <= dif.min_tick ? cyc_q + 6'h01 : cyc_q;
      first_q <= dif.min_tick ? 1'b1 : (wrap ? 1'b0 : first_q);
      tw_q <= dif.osc_tick ? tw_q + (TW+1)'(1) : tw_q;
    end
  end
endmodule : bcr_divider

// ---- core/bcr_pkg.sv ----
package bcr_pkg;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned NFIELD = 7;
  localparam int unsigned NBANK = 8;
  localparam logic [10:0] OFF_CTRL = 11'h7f8;
  localparam logic [10:0] OFF_SEC = 11'h7f9;
  localparam logic [10:0] OFF_MIN = 11'h7fa;
  localparam logic [10:0] OFF_HOUR = 11'h7fb;
  localparam logic [10:0] OFF_WDAY = 11'h7fc;
  localparam logic [10:0] OFF_MDAY = 11'h7fd;
  localparam logic [10:0] OFF_MONTH = 11'h7fe;
  localparam logic [10:0] OFF_YEAR = 11'h7ff;
  // field index = offset minus OFF_SEC
  localparam int unsigned SEC_F = 0;
  localparam int unsigned HOUR_F = 2;
  localparam int unsigned WDAY_F = 3;
  localparam int unsigned MDAY_F = 4;
  localparam int unsigned MONTH_F = 5;
  localparam int unsigned YEAR_F = 6;
  localparam int unsigned CTL_WR_BIT = 7;
  localparam int unsigned CTL_RD_BIT = 6;
  localparam int unsigned CTL_SIGN_BIT = 5;
  localparam int unsigned CAL_W = 5;
  localparam int unsigned STOP_BIT = 7;
  localparam int unsigned FTEST_BIT = 6;
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned CAL_SHORT = 128;
  localparam int unsigned CAL_LONG = 256;
  localparam int unsigned CAL_CYCLE_MIN = 64;
  localparam int unsigned TEST_HZ = 512;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // year, month, date, weekday, hours, minutes, seconds (stop bit set)
  localparam logic [6:0][7:0] BANK_RESET = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h80};
  localparam logic [6:0][7:0] CNT_RESET = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [6:0][7:0] FIELD_LO = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [6:0][7:0] FIELD_HI = {8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h59};
  localparam logic [6:0][7:0] FIELD_MASK = {8'hff, 8'h1f, 8'h3f, 8'h07, 8'h3f, 8'h7f, 8'h7f};
  localparam logic [6:0][7:0] KEEP_MASK = {8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h80};

  function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
                   (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    unique case (mon)
      8'h02: days_in_month = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in_month = 8'h30;
      default: days_in_month = 8'h31;
    endcase
  endfunction : days_in_month
endpackage : bcr_pkg

// ---- dv/bcr_clock_core_monitor.sv ----
module bcr_clock_core_monitor #(
  parameter int unsigned OSC_HZ = bcr_pkg::OSC_HZ // divider length
) (
  input wire logic CLOCK, // system clock
  input wire logic RST_N, // sync reset
  input wire logic OSC_IN, // oscillator pin
  input wire logic [bcr_pkg::ADDR_W-1:0] ADDR, // byte address
  input wire logic E_N, // chip select
  input wire logic W_N, // write strobe
  input wire logic G_N, // output enable
  input wire logic [7:0] DQ_IN, // data in
  input wire logic [7:0] DQ_OUT, // read data
  input wire logic DQ_OE // data driven
);
  import bcr_pkg::*;
  logic [2:0] up_q;
  logic [3:0] rq_q;
  logic [10:0] ap_q [4];
  logic rd_ok;
  logic [7:0] q;
  always_ff @(posedge CLOCK) begin
    up_q <= !RST_N ? 3'h0 : (up_q == 3'h7 ? up_q : up_q + 3'h1);
    rq_q <= {rq_q[2:0], !E_N && W_N && !G_N};
    ap_q <= '{ADDR, ap_q[0], ap_q[1], ap_q[2]};
  end
  // pins reach the read data through three stages; skip cycles where the address just moved
  assign rd_ok = DQ_OE && up_q >= 3'h5 && ap_q[2] == ap_q[3];
  assign q = DQ_OUT;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  a_oe_follows_read: assert property (up_q >= 3'h5 |-> DQ_OE == rq_q[2])
    else $error("output enable does not follow read strobes");
  a_write_quiet: assert property ((!E_N && !W_N) [*4] |-> !DQ_OE)
    else $error("data driven during write");
  a_unmapped_zero: assert property (rd_ok && ap_q[2] < OFF_CTRL |-> q == 8'h00)
    else $error("unmapped address reads nonzero");
  a_year_bcd: assert property (rd_ok && ap_q[2] == OFF_YEAR |-> q[7:4] <= 4'h9 && q[3:0] <= 4'h9)
    else $error("year not bcd");
  a_month_range: assert property (rd_ok && ap_q[2] == OFF_MONTH |-> q inside {[8'h01:8'h09], [8'h10:8'h12]})
    else $error("month out of range");
  a_date_range: assert property (rd_ok && ap_q[2] == OFF_MDAY |->
    q inside {[8'h01:8'h09], [8'h10:8'h19], [8'h20:8'h29], [8'h30:8'h31]})
    else $error("date out of range");
  a_wday_range: assert property (rd_ok && ap_q[2] == OFF_WDAY |->
    !q[7] && q[5:3] == 3'h0 && q[2:0] != 3'h0)
    else $error("weekday out of range");
  a_hour_range: assert property (rd_ok && ap_q[2] == OFF_HOUR |->
    q inside {[8'h00:8'h09], [8'h10:8'h19], [8'h20:8'h23]})
    else $error("hours out of range");
  a_min_range: assert property (rd_ok && ap_q[2] == OFF_MIN |-> !q[7] && q[6:4] <= 3'h5 && q[3:0] <= 4'h9)
    else $error("minutes out of range");
  a_sec_range: assert property (rd_ok && ap_q[2] == OFF_SEC |-> q[6:4] <= 3'h5 && q[3:0] <= 4'h9)
    else $error("seconds out of range");
  c_sec_read: cover property (rd_ok && ap_q[2] == OFF_SEC);
  c_write: cover property ((!E_N && !W_N) [*4]);
  c_unmapped: cover property (rd_ok && ap_q[2] < OFF_CTRL);
endmodule : bcr_clock_core_monitor

// ---- dv/bcr_host_model.sv ----
module bcr_host_model (
  input wire logic clk, // bus timing
  output logic [10:0] addr, // byte address
  output logic e_n, // chip select
  output logic w_n, // write strobe
  output logic g_n, // output enable
  output logic [7:0] dq_drv, // data driven
  input wire logic [7:0] dq_bus, // data wire level
  input wire logic dq_oe // device drives
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr = 11'h000;
    e_n = 1'b1;
    w_n = 1'b1;
    g_n = 1'b1;
    dq_drv = 8'h00;
  end
  // address and data held past the synchronised end of the strobe overlap
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    dq_drv <= d;
    e_n <= 1'b0;
    w_n <= 1'b0;
    repeat (5) @(posedge clk);
    e_n <= 1'b1;
    w_n <= 1'b1;
    repeat (4) @(posedge clk);
    dq_drv <= ~d;
  endtask : wr
  task automatic rd(input logic [10:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    @(posedge clk);
    addr <= a;
    e_n <= 1'b0;
    g_n <= 1'b0;
    for (int i = 0; i < 12 && !ok; i++) begin
      @(posedge clk);
      ok = (dq_oe === 1'b1);
    end
    d = dq_bus;
    e_n <= 1'b1;
    g_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rd
  // held seconds read with halt clear, counting changes of data bit zero
  task automatic long_rd(input int unsigned cyc, output int unsigned n);
    logic last;
    n = 0;
    @(posedge clk);
    addr <= bcr_pkg::OFF_SEC;
    e_n <= 1'b0;
    g_n <= 1'b0;
    repeat (6) @(posedge clk);
    last = dq_bus[0];
    repeat (cyc) begin
      @(posedge clk);
      n = n + 32'(dq_bus[0] !== last);
      last = dq_bus[0];
    end
    e_n <= 1'b1;
    g_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : long_rd
endmodule : bcr_host_model

// ---- dv/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import bcr_pkg::*;
  localparam int unsigned OSC_SIM = 1024;
  localparam int unsigned SEC_CYC = OSC_SIM * 8;
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned TOG_WIN = 512;
  // the test square wave changes level twice per period
  localparam logic [7:0] TOG_EXP = 8'(TOG_WIN * 2 * TEST_HZ / SEC_CYC);
  // first second of a trimmed minute with positive sign, in units of 64 clocks
  localparam logic [7:0] CAL_EXP = 8'((SEC_CYC - CAL_SHORT * (SEC_CYC / OSC_SIM)) / 64);
  localparam logic [7:0] RST_IMG [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0] LOAD_IMG [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  localparam logic [7:0] ROLL_IMG [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc = 1'b0;
  logic [10:0] addr;
  logic e_n, w_n, g_n, dq_oe, ok;
  logic [7:0] dq_drv, dq_out, rd_d, snap;
  wire [7:0] dq_bus = dq_oe ? dq_out : dq_drv;
  int n_errors = 0;
  int checks_done = 0;
  int unsigned tog;
  time t0;
  always #50 clk = ~clk;
  always #400 osc = ~osc;
  bcr_clock_core #(.OSC_HZ(OSC_SIM)) u_dut (.CLOCK(clk), .RST_N(rst_n), .OSC_IN(osc), .ADDR(addr), .E_N(e_n),
    .W_N(w_n), .G_N(g_n), .DQ_IN(dq_bus), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
  bcr_host_model u_host (.clk(clk), .addr(addr), .e_n(e_n), .w_n(w_n), .g_n(g_n), .dq_drv(dq_drv),
    .dq_bus(dq_bus), .dq_oe(dq_oe));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask : chk
  task automatic get(input logic [10:0] a);
    u_host.rd(a, rd_d, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      conclude();
    end
  endtask : get
  task automatic rdc(input logic [10:0] a, input logic [7:0] e);
    get(a);
    chk(rd_d, e, e);
  endtask : rdc
  // read until the value moves, bounded to about two seconds
  task automatic poll(input logic [10:0] a, input logic [7:0] old);
    rd_d = old;
    for (int i = 0; i < 2000 && rd_d === old; i++)
      get(a);
    if (rd_d === old) begin
      n_errors++;
      conclude();
    end
  endtask : poll
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      rdc(OFF_CTRL + 11'(i), RST_IMG[i]);
    u_host.wr(11'h000, 8'h5a);
    rdc(11'h000, 8'h00);
    rdc(11'h7f7, 8'h00);
    $display("end reset");
    repeat (SEC_CYC + SEC_CYC / 4) @(posedge clk);
    rdc(OFF_SEC, 8'h80);
    u_host.wr(OFF_SEC, 8'h00);
    rdc(OFF_SEC, 8'h00);
    poll(OFF_SEC, 8'h00);
    chk(rd_d, 8'h01, 8'h01);
    $display("end stop");
    u_host.wr(OFF_CTRL, 8'h3f);
    rdc(OFF_CTRL, 8'h3f);
    u_host.wr(OFF_CTRL, 8'h80);
    for (int i = 0; i < 7; i++)
      u_host.wr(OFF_SEC + 11'(i), LOAD_IMG[i]);
    rdc(OFF_YEAR, 8'h99);
    // clearing the load bit also sets a one-step positive trim
    u_host.wr(OFF_CTRL, 8'h21);
    rdc(OFF_MIN, 8'h59);
    poll(OFF_SEC, 8'h59);
    t0 = $time;
    for (int i = 0; i < 7; i++)
      rdc(OFF_SEC + 11'(i), ROLL_IMG[i]);
    poll(OFF_SEC, 8'h00);
    chk(8'(($time - t0) / (CLK_NS * 64)), CAL_EXP - 8'h01, CAL_EXP + 8'h01);
    $display("end load");
    u_host.wr(OFF_CTRL, 8'h40);
    get(OFF_SEC);
    snap = rd_d;
    repeat (2 * SEC_CYC + SEC_CYC / 2) @(posedge clk);
    rdc(OFF_SEC, snap);
    u_host.wr(OFF_CTRL, 8'h00);
    get(OFF_SEC);
    chk(rd_d, snap + 8'h02, snap + 8'h03);
    $display("end halt");
    u_host.wr(OFF_WDAY, 8'h41);
    rdc(OFF_WDAY, 8'h41);
    u_host.long_rd(TOG_WIN, tog);
    chk(8'(tog), TOG_EXP - 8'h01, TOG_EXP + 8'h01);
    u_host.wr(OFF_WDAY, 8'h01);
    rdc(OFF_WDAY, 8'h01);
    u_host.long_rd(1024, tog);
    chk(8'(tog), 8'h00, 8'h01);
    $display("end test bit");
    conclude();
  end
endmodule : testbench

bind bcr_clock_core bcr_clock_core_monitor #(.OSC_HZ(OSC_HZ)) u_mon (.CLOCK(CLOCK), .RST_N(RST_N), .OSC_IN(OSC_IN),
  .ADDR(ADDR), .E_N(E_N), .W_N(W_N), .G_N(G_N), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE));
